// file: logic/gated_latch_array.sv
`timescale 1ns/10ps
`default_nettype none
`include "gated_latch_defines.svh"

// ==========================================================================
// gated latch array: set/reset variant and data variant side by side
// ==========================================================================
// the latches are modelled on the system clock: the levels of the shared
// controls and of each latch input are sampled every edge, and the outputs
// show the result one cycle later. this trades a cycle of latency for a
// design free of real latches and combinational loops.

module gated_latch_array #(
    parameter int unsigned LATCH_COUNT = `LATCH_COUNT_DEFAULT
) (
    input  wire logic                   sys_clk_i,         // system clock
    input  wire logic                   sys_rst_i,         // synchronous reset, high
    input  wire logic                   preset_n_i,        // shared preset, active low
    input  wire logic                   clear_n_i,         // shared clear, active low
    input  wire logic                   gate_i,            // shared gate level
    input  wire logic [LATCH_COUNT-1:0] set_i,             // set inputs
    input  wire logic [LATCH_COUNT-1:0] reset_i,           // reset inputs
    input  wire logic [LATCH_COUNT-1:0] data_i,            // data inputs
    output var  logic [LATCH_COUNT-1:0] sr_q_o,            // set/reset true outputs
    output var  logic [LATCH_COUNT-1:0] sr_q_complement_o, // set/reset complements
    output var  logic [LATCH_COUNT-1:0] sr_unstable_o,     // set/reset unstable flags
    output var  logic [LATCH_COUNT-1:0] dl_q_o,            // data latch true outputs
    output var  logic [LATCH_COUNT-1:0] dl_q_complement_o, // data latch complements
    output var  logic [LATCH_COUNT-1:0] dl_unstable_o      // data latch unstable flags
);

    // ======================================================================
    // shared control decode
    // ======================================================================
    latch_ctrl_if ctrl ();

    // a single decoder serves both arrays so every latch sees one mode
    latch_mode_decode u_decode (
        .preset_n_i (preset_n_i),
        .clear_n_i  (clear_n_i),
        .gate_i     (gate_i),
        .ctrl       (ctrl.decoder)
    );

    // named mode strobes used by both arrays
    wire logic mode_clear;
    wire logic mode_preset;
    wire logic mode_conflict;
    wire logic mode_open;

    assign mode_clear    = (ctrl.mode == gated_latch_pkg::MODE_CLEAR);
    assign mode_preset   = (ctrl.mode == gated_latch_pkg::MODE_PRESET);
    assign mode_conflict = (ctrl.mode == gated_latch_pkg::MODE_CONFLICT);
    assign mode_open     = (ctrl.mode == gated_latch_pkg::MODE_OPEN);

    // ======================================================================
    // next values, one slice per latch
    // ======================================================================
    wire logic [LATCH_COUNT-1:0] sr_q_d;
    wire logic [LATCH_COUNT-1:0] sr_qc_d;
    wire logic [LATCH_COUNT-1:0] sr_unst_d;
    wire logic [LATCH_COUNT-1:0] dl_q_d;
    wire logic [LATCH_COUNT-1:0] dl_qc_d;
    wire logic [LATCH_COUNT-1:0] dl_unst_d;

    for (genvar i = 0; i < LATCH_COUNT; i++) begin : g_latch
        // set/reset input combinations seen while the gate is open
        wire logic sr_set;
        wire logic sr_rst;
        wire logic sr_both;

        assign sr_set  = mode_open & set_i[i] & ~reset_i[i];
        assign sr_rst  = mode_open & ~set_i[i] & reset_i[i];
        assign sr_both = mode_open & set_i[i] & reset_i[i];

        // overrides first, then gate level; hold otherwise covers gate low
        // and the open gate with set and reset both low
        assign sr_q_d[i] = mode_clear                ? 1'b0 :
                           mode_preset               ? 1'b1 :
                           (mode_conflict | sr_both) ? 1'bx :
                           sr_set                    ? 1'b1 :
                           sr_rst                    ? 1'b0 :
                                                       sr_q_o[i];

        assign sr_qc_d[i] = mode_clear                ? 1'b1 :
                            mode_preset               ? 1'b0 :
                            (mode_conflict | sr_both) ? 1'bx :
                            sr_set                    ? 1'b0 :
                            sr_rst                    ? 1'b1 :
                                                        sr_q_complement_o[i];

        // the flag survives a hold, so a held unknown stays marked
        assign sr_unst_d[i] = (mode_conflict | sr_both) ? 1'b1 :
                              (mode_clear | mode_preset | sr_set | sr_rst) ? 1'b0 :
                                                        sr_unstable_o[i];

        // data latch: transparent while the gate is high
        assign dl_q_d[i] = mode_clear    ? 1'b0 :
                           mode_preset   ? 1'b1 :
                           mode_conflict ? 1'bx :
                           mode_open     ? data_i[i] :
                                           dl_q_o[i];

        assign dl_qc_d[i] = mode_clear    ? 1'b1 :
                            mode_preset   ? 1'b0 :
                            mode_conflict ? 1'bx :
                            mode_open     ? ~data_i[i] :
                                            dl_q_complement_o[i];

        // an open gate or a lone clear or preset always leaves a defined value
        assign dl_unst_d[i] = mode_conflict ? 1'b1 :
                              (mode_clear | mode_preset | mode_open) ? 1'b0 :
                                              dl_unstable_o[i];
    end

    // ======================================================================
    // storage, one bank per variant, sized by the latch count
    // ======================================================================
    // outputs come straight from the bank flops
    latch_storage #(
        .WIDTH (LATCH_COUNT)
    ) u_sr_bank (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .q_d_i     (sr_q_d),
        .qc_d_i    (sr_qc_d),
        .unst_d_i  (sr_unst_d),
        .q_o       (sr_q_o),
        .qc_o      (sr_q_complement_o),
        .unst_o    (sr_unstable_o)
    );

    latch_storage #(
        .WIDTH (LATCH_COUNT)
    ) u_dl_bank (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .q_d_i     (dl_q_d),
        .qc_d_i    (dl_qc_d),
        .unst_d_i  (dl_unst_d),
        .q_o       (dl_q_o),
        .qc_o      (dl_q_complement_o),
        .unst_o    (dl_unstable_o)
    );

    // ======================================================================
    // checks
    // ======================================================================
    // stability checks only look at arrays with no latch marked unstable,
    // since an unknown pair cannot be compared with itself
    wire logic ctrl_clear;
    wire logic ctrl_preset;
    wire logic ctrl_open;
    wire logic ctrl_closed;
    wire logic sr_all_defined;
    wire logic dl_all_defined;

    assign ctrl_clear     = preset_n_i & ~clear_n_i;
    assign ctrl_preset    = ~preset_n_i & clear_n_i;
    assign ctrl_open      = preset_n_i & clear_n_i & gate_i;
    assign ctrl_closed    = preset_n_i & clear_n_i & ~gate_i;
    assign sr_all_defined = (sr_unstable_o == '0);
    assign dl_all_defined = (dl_unstable_o == '0);

    a_clear_forces_low: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ctrl_clear |=> (sr_q_o == '0) && (sr_q_complement_o == '1)
                    && (dl_q_o == '0) && (dl_q_complement_o == '1))
        else $error("clear did not force outputs low");

    a_preset_forces_high: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ctrl_preset |=> (sr_q_o == '1) && (sr_q_complement_o == '0)
                     && (dl_q_o == '1) && (dl_q_complement_o == '0))
        else $error("preset did not force outputs high");

    a_conflict_marks_unstable: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (!preset_n_i && !clear_n_i) |=> (sr_unstable_o == '1) && (dl_unstable_o == '1))
        else $error("preset with clear not flagged unstable");

    a_sr_gate_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (ctrl_closed && sr_all_defined) |=> $stable(sr_q_o) && $stable(sr_q_complement_o)
                                         && sr_all_defined)
        else $error("set/reset latch changed with gate low");

    a_sr_idle_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (ctrl_open && sr_all_defined)
        |=> (((sr_q_o ^ $past(sr_q_o)) & ~($past(set_i) | $past(reset_i))) == '0))
        else $error("set/reset latch moved with set and reset low");

    a_sr_reset_low: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ctrl_open |=> ((sr_q_o & ~$past(set_i) & $past(reset_i)) == '0)
                   && ((~sr_q_complement_o & ~$past(set_i) & $past(reset_i)) == '0))
        else $error("reset did not clear the set/reset latch");

    a_sr_set_high: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ctrl_open |=> ((~sr_q_o & $past(set_i) & ~$past(reset_i)) == '0)
                   && ((sr_q_complement_o & $past(set_i) & ~$past(reset_i)) == '0))
        else $error("set did not set the set/reset latch");

    a_sr_both_unstable: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ctrl_open |=> ((~sr_unstable_o & $past(set_i) & $past(reset_i)) == '0)
                   && ((sr_unstable_o & ($past(set_i) ^ $past(reset_i))) == '0))
        else $error("set with reset not flagged unstable");

    a_dl_transparent: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ctrl_open |=> (dl_q_o == $past(data_i)) && (dl_q_complement_o == ~$past(data_i))
                   && dl_all_defined)
        else $error("data latch not transparent with gate high");

    a_dl_gate_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (ctrl_closed && dl_all_defined) |=> $stable(dl_q_o) && $stable(dl_q_complement_o))
        else $error("data latch changed with gate low");

    a_shared_gate_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (ctrl_closed && sr_all_defined && dl_all_defined) [*2]
        |=> $stable(sr_q_o) && $stable(dl_q_o))
        else $error("a latch moved while the shared gate was low");

    a_level_follow: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ctrl_open ##1 ctrl_open |=> (dl_q_o == $past(data_i))
                                 && (dl_q_complement_o == ~$past(data_i)))
        else $error("data latch stopped following with gate held high");

    a_unstable_clears: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (!preset_n_i && !clear_n_i) ##1 ctrl_clear
        |=> sr_all_defined && dl_all_defined && (dl_q_o == '0))
        else $error("unstable flag not cleared by clear");

    // ======================================================================
    // pairing and flag checks
    // ======================================================================
    // a latch whose flag is low must show a proper true/complement pair,
    // otherwise downstream logic would trust a value that is not safe;
    // an unknown pair is let through only where the flag is raised
    a_sr_pair_valid: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ((sr_q_o ^ sr_q_complement_o) | sr_unstable_o) == '1)
        else $error("defined set/reset latch without a complement pair");

    a_dl_pair_valid: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ((dl_q_o ^ dl_q_complement_o) | dl_unstable_o) == '1)
        else $error("defined data latch without a complement pair");

    // one override writes a defined value into every latch of both arrays
    a_override_defines: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (ctrl_clear || ctrl_preset) |=> sr_all_defined && dl_all_defined)
        else $error("override left a latch flagged unstable");

    // a closed gate keeps the flags too, so a held unknown stays marked
    a_sr_flag_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ctrl_closed |=> $stable(sr_unstable_o))
        else $error("set/reset flags changed with gate low");

    a_dl_flag_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ctrl_closed |=> $stable(dl_unstable_o))
        else $error("data latch flags changed with gate low");

    a_sr_idle_flag: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ctrl_open |=> (((sr_unstable_o ^ $past(sr_unstable_o)) & ~($past(set_i) | $past(reset_i))) == '0))
        else $error("set/reset flag moved with set and reset low");

    // the falling gate must not update: the last open sample stands
    a_gate_fall_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ctrl_open ##1 (ctrl_closed && dl_all_defined) |=> $stable(dl_q_o) && $stable(dl_q_complement_o))
        else $error("data latch updated on the falling gate");

    // the first high level already updates, no edge is waited for
    a_gate_rise_update: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ctrl_closed ##1 ctrl_open |=> (dl_q_o == $past(data_i)) && dl_all_defined)
        else $error("data latch missed the first cycle of an open gate");

    // the conflict beats an open gate as well
    a_conflict_over_gate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (!preset_n_i && !clear_n_i && gate_i) |=> (sr_unstable_o == '1) && (dl_unstable_o == '1))
        else $error("open gate hid a preset with clear conflict");

    // flags only rise on a conflict or on an open gate
    a_flag_source: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (ctrl_clear || ctrl_preset || ctrl_closed)
        |=> ((sr_unstable_o & ~$past(sr_unstable_o)) == '0)
         && ((dl_unstable_o & ~$past(dl_unstable_o)) == '0))
        else $error("unstable flag rose without a cause");

    // reset leaves every latch cleared and defined, so the
    // first cycle after release starts from a known pair
    a_reset_state: assert property (@(posedge sys_clk_i)
        sys_rst_i |=> (sr_q_o == '0) && (sr_q_complement_o == '1) && (sr_unstable_o == '0)
                   && (dl_q_o == '0) && (dl_q_complement_o == '1) && (dl_unstable_o == '0))
        else $error("reset did not leave every latch cleared");

endmodule

`default_nettype wire

// file: logic/gated_latch_defines.svh
`ifndef GATED_LATCH_DEFINES_SVH
`define GATED_LATCH_DEFINES_SVH

// ==========================================================================
// array size and reset values
// ==========================================================================
// default number of latches in each array
`define LATCH_COUNT_DEFAULT 4
// true output after reset: cleared
`define LATCH_RESET_Q 1'b0
// complement output after reset
`define LATCH_RESET_QC 1'b1
// unstable marker after reset
`define LATCH_RESET_UNSTABLE 1'b0

`endif

// file: logic/gated_latch_pkg.sv
`default_nettype none

package gated_latch_pkg;

    // ======================================================================
    // shared control modes
    // ======================================================================
    // one mode for the whole array, decoded from preset, clear and gate
    typedef enum logic [2:0] {
        MODE_CLEAR    = 3'b000, // clear active alone
        MODE_PRESET   = 3'b001, // preset active alone
        MODE_CONFLICT = 3'b010, // preset and clear both active
        MODE_HOLD     = 3'b011, // both inactive, gate low
        MODE_OPEN     = 3'b100  // both inactive, gate high
    } latch_mode_t;

endpackage

`default_nettype wire

// file: logic/latch_ctrl_if.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// shared control carrier between decoder and latch arrays
// ==========================================================================
interface latch_ctrl_if;
    gated_latch_pkg::latch_mode_t mode; // array-wide mode

    modport decoder (output mode);
    modport bank    (input  mode);
endinterface

`default_nettype wire

// file: logic/latch_mode_decode.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// decode of the shared preset, clear and gate levels
// ==========================================================================
module latch_mode_decode (
    input  wire logic      preset_n_i, // shared preset, active low
    input  wire logic      clear_n_i,  // shared clear, active low
    input  wire logic      gate_i,     // shared gate level
    latch_ctrl_if.decoder  ctrl        // decoded mode out
);

    // preset and clear override the gate, so they are decoded first
    wire logic clear_only;
    wire logic preset_only;
    wire logic both_active;

    assign clear_only  = preset_n_i & ~clear_n_i;
    assign preset_only = ~preset_n_i & clear_n_i;
    assign both_active = ~preset_n_i & ~clear_n_i;

    // gate only matters once both overrides are released
    assign ctrl.mode = clear_only  ? gated_latch_pkg::MODE_CLEAR :
                       preset_only ? gated_latch_pkg::MODE_PRESET :
                       both_active ? gated_latch_pkg::MODE_CONFLICT :
                       gate_i      ? gated_latch_pkg::MODE_OPEN :
                                     gated_latch_pkg::MODE_HOLD;

endmodule

`default_nettype wire

// file: logic/latch_storage.sv
`timescale 1ns/10ps
`default_nettype none
`include "gated_latch_defines.svh"

// ==========================================================================
// storage flops for one latch array
// ==========================================================================
module latch_storage #(
    parameter int unsigned WIDTH = `LATCH_COUNT_DEFAULT
) (
    input  wire logic             sys_clk_i,  // system clock
    input  wire logic             sys_rst_i,  // synchronous reset, high
    input  wire logic [WIDTH-1:0] q_d_i,      // next true value
    input  wire logic [WIDTH-1:0] qc_d_i,     // next complement value
    input  wire logic [WIDTH-1:0] unst_d_i,   // next unstable marker
    output var  logic [WIDTH-1:0] q_o,        // true outputs, registered
    output var  logic [WIDTH-1:0] qc_o,       // complement outputs, registered
    output var  logic [WIDTH-1:0] unst_o      // unstable markers, registered
);

    // true and complement are kept apart so an unknown pair stays unknown
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            q_o    <= {WIDTH{`LATCH_RESET_Q}};
            qc_o   <= {WIDTH{`LATCH_RESET_QC}};
            unst_o <= {WIDTH{`LATCH_RESET_UNSTABLE}};
        end else begin
            q_o    <= q_d_i;
            qc_o   <= qc_d_i;
            unst_o <= unst_d_i;
        end
    end

endmodule

`default_nettype wire

// file: verification/latch_driver.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// surrounding logic that drives the shared controls and per-latch inputs
// ==========================================================================
module latch_driver #(
    parameter int unsigned N = 4
) (
    input  wire logic [3*N+2:0] cmd_i,      // {preset_n, clear_n, gate, set, reset, data}
    input  wire logic           rst_cmd_i,  // commanded reset level
    input  wire logic           sys_clk_i,  // system clock
    output var  logic           rst_o,      // reset to the design
    output var  logic           preset_n_o, // shared preset, active low
    output var  logic           clear_n_o,  // shared clear, active low
    output var  logic           gate_o,     // shared gate
    output var  logic [N-1:0]   set_o,      // set inputs
    output var  logic [N-1:0]   reset_o,    // reset inputs
    output var  logic [N-1:0]   data_o      // data inputs
);
    // defined levels from time zero, reset held until the bench lets go
    initial begin
        {rst_o, preset_n_o, clear_n_o, gate_o} = 4'hf;
        {set_o, reset_o, data_o} = '0;
    end

    // launch 2 ns after the edge so no change ever lands on a sampling edge
    always @(posedge sys_clk_i) begin
        #2;
        rst_o <= rst_cmd_i;
        {preset_n_o, clear_n_o, gate_o, set_o, reset_o, data_o} <= cmd_i;
    end
endmodule

`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// self-checking bench for the gated latch array
// ==========================================================================
module testbench;
    localparam int unsigned N = 6;        // not the default, so the width parameter is exercised
    localparam int unsigned W = 3 * N + 3;
    localparam int unsigned E = 6 * N;

    logic           sys_clk;
    logic           rst_cmd;
    logic [W-1:0]   cmd;
    logic [E-1:0]   exp_q;
    logic           chk_en;
    int             err_count;
    int             cmp_count;
    int             cyc;
    wire            rst;
    wire            preset_n;
    wire            clear_n;
    wire            gate;
    wire  [N-1:0]   set_v;
    wire  [N-1:0]   reset_v;
    wire  [N-1:0]   data_v;
    wire  [N-1:0]   sr_q;
    wire  [N-1:0]   sr_qc;
    wire  [N-1:0]   sr_un;
    wire  [N-1:0]   dl_q;
    wire  [N-1:0]   dl_qc;
    wire  [N-1:0]   dl_un;

    latch_driver #(.N(N)) drv_u (.cmd_i(cmd), .rst_cmd_i(rst_cmd), .sys_clk_i(sys_clk), .rst_o(rst),
        .preset_n_o(preset_n), .clear_n_o(clear_n), .gate_o(gate), .set_o(set_v), .reset_o(reset_v),
        .data_o(data_v));

    gated_latch_array #(.LATCH_COUNT(N)) dut_u (.sys_clk_i(sys_clk), .sys_rst_i(rst), .preset_n_i(preset_n),
        .clear_n_i(clear_n), .gate_i(gate), .set_i(set_v), .reset_i(reset_v), .data_i(data_v),
        .sr_q_o(sr_q), .sr_q_complement_o(sr_qc), .sr_unstable_o(sr_un), .dl_q_o(dl_q),
        .dl_q_complement_o(dl_qc), .dl_unstable_o(dl_un));

    // ======================================================================
    // clock and hang guard
    // ======================================================================
    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end

    // about 620 cycles are expected; the ceiling leaves ample slack
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            report_and_stop();
        end
    end

    // ======================================================================
    // expectation model
    // ======================================================================
    // one bit at a time, since every latch shares only the three controls
    function automatic logic [E-1:0] next_exp(input logic [W-1:0] v, input logic [E-1:0] cur);
        logic         pn;
        logic         cn;
        logic         g;
        logic [N-1:0] s;
        logic [N-1:0] r;
        logic [N-1:0] d;
        logic [N-1:0] sq;
        logic [N-1:0] sc;
        logic [N-1:0] su;
        logic [N-1:0] dq;
        logic [N-1:0] dc;
        logic [N-1:0] du;
        {pn, cn, g, s, r, d} = v;
        {sq, sc, su, dq, dc, du} = cur;
        for (int i = 0; i < N; i++) begin
            if (!pn || !cn) begin
                // both overrides give x with the flag; one alone gives q = !preset_n, qc = !clear_n
                {sq[i], sc[i], su[i]} = (!pn && !cn) ? {2'hx, 1'h1} : {!pn, !cn, 1'h0};
                {dq[i], dc[i], du[i]} = {sq[i], sc[i], su[i]};
            end else if (g) begin
                {dq[i], dc[i], du[i]} = {d[i], !d[i], 1'h0};
                case ({s[i], r[i]})
                    2'h1: {sq[i], sc[i], su[i]} = 3'h2;
                    2'h2: {sq[i], sc[i], su[i]} = 3'h4;
                    2'h3: {sq[i], sc[i], su[i]} = {2'hx, 1'h1};
                    default: ;
                endcase
            end
        end
        return {sq, sc, su, dq, dc, du};
    endfunction

    // random level set, weighted towards the open and closed gate
    function automatic logic [W-1:0] rnd_stim();
        int unsigned m;
        logic        g;
        m = $urandom % 8;
        g = (m > 4) ? 1'h1 : ((m < 3) ? 1'($urandom) : 1'h0);
        return {1'(m != 1 && m != 2), 1'(m != 0 && m != 2), g, N'($urandom), N'($urandom), N'($urandom)};
    endfunction

    // ======================================================================
    // checks and stepping
    // ======================================================================
    task automatic check(input string name, input logic [N-1:0] e, input logic [N-1:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask

    // checks what the last edge produced, then commands the next level set
    task automatic step(input logic r, input logic [W-1:0] v);
        @(posedge sys_clk);
        #1;
        if (chk_en) begin
            check("sr_q", exp_q[E-1 -: N], sr_q);
            check("sr_q_complement", exp_q[5*N-1 -: N], sr_qc);
            check("sr_unstable", exp_q[4*N-1 -: N], sr_un);
            check("dl_q", exp_q[3*N-1 -: N], dl_q);
            check("dl_q_complement", exp_q[2*N-1 -: N], dl_qc);
            check("dl_unstable", exp_q[N-1:0], dl_un);
        end
        chk_en = 1'h1;
        rst_cmd = r;
        cmd = v;
        exp_q = r ? {{N{1'h0}}, {N{1'h1}}, {N{1'h0}}, {N{1'h0}}, {N{1'h1}}, {N{1'h0}}} : next_exp(v, exp_q);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ======================================================================
    // main sequence
    // ======================================================================
    // corner cases: mixed set/reset pairs, closed gate, hold of an unstable bit,
    // clear, preset, both overrides, then recovery from unstable
    logic [W-1:0] directed [8] = '{
        {3'h7, 6'h05, 6'h06, 6'h15}, {3'h6, 6'h3f, 6'h00, 6'h3f},
        {3'h7, 6'h00, 6'h00, 6'h2a}, {3'h5, 6'h3f, 6'h00, 6'h3f},
        {3'h3, 6'h00, 6'h3f, 6'h00}, {3'h0, 6'h15, 6'h2a, 6'h3f},
        {3'h7, 6'h00, 6'h00, 6'h00}, {3'h7, 6'h3f, 6'h00, 6'h01}};

    initial begin
        {rst_cmd, chk_en, err_count, cmp_count, cyc} = '0;
        cmd = '0;
        exp_q = '0;
        void'($urandom(45889));
        repeat (5) step(1'h1, rnd_stim());
        foreach (directed[i]) step(1'h0, directed[i]);
        repeat (400) step(1'h0, rnd_stim());
        repeat (2) step(1'h1, rnd_stim());
        repeat (200) step(1'h0, rnd_stim());
        step(1'h0, cmd);
        step(1'h0, cmd);
        report_and_stop();
    end
endmodule

`default_nettype wire
